// *** hw/dpc_pkg.sv ***
// Purpose: Shared constants for the dual converter output and power control block.
// Assumes: 50 MHz system clock; the sample clock is an outside input.
// Notes:   Register map, field positions, reset values and timing figures.
//
// Behaviour
// [RQ1] Each channel enable alone drives or releases that channel's outputs.
// [RQ2] Power-down select low keeps both cores converting whatever the enables.
// [RQ3] Power-down select high powers a core only while its own enable is high.
// [RQ4] A sample clock slowed toward dc puts the device into power-down.
// [RQ5] Each channel outputs a 14-bit two's complement word, bit 13 most significant.
// [RQ6] Overrange flag reads 1 while the output word sits at either full-scale limit.
// [RQ7] Each channel drives a data-ready clock beside its word for capture.
// [RQ8] The sample clock source should give close to 50% duty cycle.
// [RQ9] Conversion starts on a falling edge; the word appears 16.5 cycles later.
// [RQ10] Data-ready clock and overrange flag are released together with the data.
package dpc_pkg;
  // ==========================================================
  // Data path
  localparam int SMP_W    = 14;
  localparam int IN_W     = 16;
  localparam int NCH      = 2;
  // Latency of 16.5 sample clocks counted in half cycles.
  localparam int LAT_X2   = 33;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SLOW_HALF_NS  = 500;
  localparam int SLOW_CYC      = SLOW_HALF_NS / CLK_PERIOD_NS;
  localparam int CNT_W         = 16;
  // ==========================================================
  // Register map
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] ADDR_CTRL    = 8'h00;
  localparam logic [AXI_AW-1:0] ADDR_STATE   = 8'h04;
  localparam logic [AXI_AW-1:0] ADDR_IRQ_ST  = 8'h08;
  localparam logic [AXI_AW-1:0] ADDR_IRQ_CLR = 8'h0c;
  localparam logic [AXI_AW-1:0] ADDR_IRQ_EN  = 8'h10;
  localparam logic [CNT_W-1:0]  CTRL_RST     = CNT_W'(SLOW_CYC);
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // State register fields.
  localparam int ST_SLOW   = 0;
  localparam int ST_CORE_A = 1;
  localparam int ST_CORE_B = 2;
  localparam int ST_PDS    = 3;
  localparam int ST_OE_A   = 4;
  localparam int ST_OE_B   = 5;
  // Interrupt fields.
  localparam int IRQ_W     = 4;
  localparam int IRQ_OVR_A = 0;
  localparam int IRQ_OVR_B = 1;
  localparam int IRQ_SLOW  = 2;
  localparam int IRQ_WAKE  = 3;
  // Synchroniser lane positions.
  localparam int SY_SCLK = 0;
  localparam int SY_PDS  = 1;
  localparam int SY_OE   = 2;
  localparam int SY_SMP  = 4;
  localparam int SY_W    = SY_SMP + NCH * IN_W;

  typedef enum logic [1:0] {
    PWR_RUN  = 2'b01,
    PWR_SLOW = 2'b10
  } dpc_pwr_t;
endpackage : dpc_pkg

// *** hw/dpc_top.sv ***
// Purpose: Output, overrange, data-ready and power control of a dual converter.
// Assumes: Sample clock, pins and raw samples arrive unsynchronised.
// Notes:   Registers over AXI4-Lite; one level interrupt output.
`timescale 1ns/1ps
`default_nettype none
module dpc_top #(
  parameter int LAT_X2 = dpc_pkg::LAT_X2
) (
  input  wire  logic                          clock,
  input  wire  logic                          rst,
  input  wire  logic                          sample_clk,
  input  wire  logic                          power_down_select,
  input  wire  logic                          chan_a_output_enable,
  input  wire  logic                          chan_b_output_enable,
  input  wire  logic [dpc_pkg::IN_W-1:0]      chan_a_analog,
  input  wire  logic [dpc_pkg::IN_W-1:0]      chan_b_analog,
  output var   logic [dpc_pkg::SMP_W-1:0]     chan_a_sample,
  output var   logic [dpc_pkg::SMP_W-1:0]     chan_b_sample,
  output var   logic                          chan_a_overrange_flag,
  output var   logic                          chan_b_overrange_flag,
  output var   logic                          chan_a_data_ready_clock,
  output var   logic                          chan_b_data_ready_clock,
  output var   logic                          chan_a_out_oe,
  output var   logic                          chan_b_out_oe,
  output var   logic                          irq,
  input  wire  logic [dpc_pkg::AXI_AW-1:0]    s_axi_awaddr,
  input  wire  logic                          s_axi_awvalid,
  output var   logic                          s_axi_awready,
  input  wire  logic [31:0]                   s_axi_wdata,
  input  wire  logic [3:0]                    s_axi_wstrb,
  input  wire  logic                          s_axi_wvalid,
  output var   logic                          s_axi_wready,
  output var   logic [1:0]                    s_axi_bresp,
  output var   logic                          s_axi_bvalid,
  input  wire  logic                          s_axi_bready,
  input  wire  logic [dpc_pkg::AXI_AW-1:0]    s_axi_araddr,
  input  wire  logic                          s_axi_arvalid,
  output var   logic                          s_axi_arready,
  output var   logic [31:0]                   s_axi_rdata,
  output var   logic [1:0]                    s_axi_rresp,
  output var   logic                          s_axi_rvalid,
  input  wire  logic                          s_axi_rready
);
  localparam int W  = dpc_pkg::SMP_W;
  localparam int IW = dpc_pkg::IN_W;
  localparam int N  = dpc_pkg::NCH;
  localparam int CW = dpc_pkg::CNT_W;
  localparam int QW = dpc_pkg::IRQ_W;

  function automatic logic [W-1:0] sat_word(input logic [IW-1:0] raw);
    logic signed [IW-1:0] s;
    logic signed [IW-1:0] hi;
    logic signed [IW-1:0] lo;
    s  = $signed(raw);
    hi = IW'(signed'({1'b0, {(W-1){1'b1}}}));
    lo = -hi - IW'(1);
    if (s > hi) begin
      return W'(hi);
    end else if (s < lo) begin
      return W'(lo);
    end
    return W'(s);
  endfunction : sat_word

  function automatic logic at_limit(input logic [W-1:0] w);
    return (w == {1'b0, {(W-1){1'b1}}}) || (w == {1'b1, {(W-1){1'b0}}});
  endfunction : at_limit

  function automatic logic [CW-1:0] strb_merge(input logic [CW-1:0] old,
                                               input logic [31:0] d,
                                               input logic [3:0] be);
    logic [CW-1:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = d[7:0];
    end
    if (be[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction : strb_merge

  // ==========================================================
  // Input synchronisers
  // Stage one is read only by stage two; the raw sample bus is taken half a
  // sample period after it settles, so its bits cannot straddle a change.
  logic [dpc_pkg::SY_W-1:0] sy1_ff;
  logic [dpc_pkg::SY_W-1:0] sy2_ff;
  logic                     sclk_d_ff;
  logic [dpc_pkg::SY_W-1:0] sy_raw;

  always_comb begin
    sy_raw = {chan_b_analog, chan_a_analog, chan_b_output_enable,
              chan_a_output_enable, power_down_select, sample_clk};
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sy1_ff    <= '0;
      sy2_ff    <= '0;
      sclk_d_ff <= 1'b0;
    end else begin
      sy1_ff    <= sy_raw;
      sy2_ff    <= sy1_ff;
      sclk_d_ff <= sy2_ff[dpc_pkg::SY_SCLK];
    end
  end

  logic         sclk;
  logic         pds;
  logic [N-1:0] oe;
  logic         edge_any;
  logic         edge_fall;
  logic         edge_rise;

  always_comb begin
    sclk      = sy2_ff[dpc_pkg::SY_SCLK];
    pds       = sy2_ff[dpc_pkg::SY_PDS];
    oe        = sy2_ff[dpc_pkg::SY_OE +: N];
    edge_any  = sclk ^ sclk_d_ff;
    edge_fall = sclk_d_ff & ~sclk;
    edge_rise = sclk & ~sclk_d_ff;
  end

  // ==========================================================
  // Slow clock power-down
  // The idle count restarts on every sample clock edge, so a stopped clock
  // and a slow one are handled alike. The threshold is software's to move.
  dpc_pkg::dpc_pwr_t pwr_ff;
  dpc_pkg::dpc_pwr_t nxt_pwr;
  logic [CW-1:0]     idle_ff;
  logic [CW-1:0]     nxt_idle;
  logic [CW-1:0]     thresh_ff;
  logic              ev_slow;
  logic              ev_wake;
  logic [N-1:0]      core_on;

  always_comb begin
    nxt_pwr  = pwr_ff;
    nxt_idle = idle_ff;
    ev_slow  = 1'b0;
    ev_wake  = 1'b0;
    if (edge_any) begin
      nxt_idle = '0;
    end else if (idle_ff != '1) begin
      nxt_idle = idle_ff + CW'(1);
    end
    case (pwr_ff)
      dpc_pkg::PWR_RUN: begin
        if (!edge_any && idle_ff >= thresh_ff) begin
          nxt_pwr = dpc_pkg::PWR_SLOW; // [RQ4]
          ev_slow = 1'b1;
        end
      end
      dpc_pkg::PWR_SLOW: begin
        if (edge_any) begin
          nxt_pwr = dpc_pkg::PWR_RUN;
          ev_wake = 1'b1;
        end
      end
      default: begin
        nxt_pwr = dpc_pkg::PWR_RUN;
      end
    endcase
    for (int c = 0; c < N; c++) begin
      core_on[c] = (~pds | oe[c]) & (pwr_ff == dpc_pkg::PWR_RUN); // [RQ2] [RQ3]
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pwr_ff  <= dpc_pkg::PWR_RUN;
      idle_ff <= '0;
    end else begin
      pwr_ff  <= nxt_pwr;
      idle_ff <= nxt_idle;
    end
  end

  // ==========================================================
  // Conversion pipeline and output pins
  // One stage per sample clock half period; a powered-down core is flushed so
  // that no stale word escapes when it wakes.
  logic [W:0]     pipe_ff     [N][LAT_X2];
  logic [W:0]     nxt_pipe    [N][LAT_X2];
  logic [W-1:0]   word_ff     [N];
  logic [W-1:0]   nxt_word    [N];
  logic [N-1:0]   ovr_ff;
  logic [N-1:0]   nxt_ovr;
  logic [N-1:0]   drc_ff;
  logic [N-1:0]   nxt_drc;
  logic [N-1:0]   oe_ff;
  logic [IW-1:0]  raw         [N];

  always_comb begin
    for (int c = 0; c < N; c++) begin
      raw[c]      = sy2_ff[dpc_pkg::SY_SMP + c * IW +: IW];
      nxt_word[c] = word_ff[c];
      for (int i = 0; i < LAT_X2; i++) begin
        nxt_pipe[c][i] = pipe_ff[c][i];
      end
      if (!core_on[c]) begin
        for (int i = 0; i < LAT_X2; i++) begin
          nxt_pipe[c][i] = '0;
        end
        nxt_word[c] = '0;
      end else if (edge_any) begin
        for (int i = 1; i < LAT_X2; i++) begin
          nxt_pipe[c][i] = pipe_ff[c][i-1];
        end
        nxt_pipe[c][0] = {edge_fall, sat_word(raw[c])}; // [RQ9] [RQ5]
        if (pipe_ff[c][LAT_X2-1][W]) begin
          nxt_word[c] = pipe_ff[c][LAT_X2-1][W-1:0]; // [RQ9]
        end
      end
      nxt_ovr[c] = at_limit(nxt_word[c]) & core_on[c]; // [RQ6]
      nxt_drc[c] = core_on[c] & ~sclk; // [RQ7]
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < N; c++) begin
        word_ff[c] <= '0;
        for (int i = 0; i < LAT_X2; i++) begin
          pipe_ff[c][i] <= '0;
        end
      end
      ovr_ff <= '0;
      drc_ff <= '0;
      oe_ff  <= '0;
    end else begin
      for (int c = 0; c < N; c++) begin
        word_ff[c] <= nxt_word[c];
        for (int i = 0; i < LAT_X2; i++) begin
          pipe_ff[c][i] <= nxt_pipe[c][i];
        end
      end
      ovr_ff <= nxt_ovr;
      drc_ff <= nxt_drc;
      oe_ff  <= oe; // [RQ1] [RQ10]
    end
  end

  always_comb begin
    chan_a_sample           = word_ff[0];
    chan_b_sample           = word_ff[1];
    chan_a_overrange_flag   = ovr_ff[0];
    chan_b_overrange_flag   = ovr_ff[1];
    chan_a_data_ready_clock = drc_ff[0];
    chan_b_data_ready_clock = drc_ff[1];
    chan_a_out_oe           = oe_ff[0];
    chan_b_out_oe           = oe_ff[1];
  end

  // ==========================================================
  // AXI4-Lite slave and interrupt
  logic              aw_have_ff, w_have_ff, bvalid_ff, rvalid_ff;
  logic              nxt_aw_have, nxt_w_have, nxt_bvalid, nxt_rvalid;
  localparam int AXI_AW_L = 0;
  logic [AXI_AW_L:0] dummy_unused;
  logic [dpc_pkg::AXI_AW-1:0] awaddr_ff, nxt_awaddr;
  logic [31:0]       wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [3:0]        wstrb_ff, nxt_wstrb;
  logic [1:0]        bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [CW-1:0]     nxt_thresh;
  logic [QW-1:0]     ist_ff, nxt_ist, ien_ff, nxt_ien, clr, ev;
  logic              irq_ff, nxt_irq;
  logic [31:0]       state_word;

  always_comb begin
    nxt_aw_have = aw_have_ff | (s_axi_awvalid & s_axi_awready);
    nxt_w_have  = w_have_ff | (s_axi_wvalid & s_axi_wready);
    nxt_awaddr  = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awaddr_ff;
    nxt_wdata   = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wdata_ff;
    nxt_wstrb   = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : wstrb_ff;
    nxt_bvalid  = bvalid_ff & ~s_axi_bready;
    nxt_bresp   = bresp_ff;
    nxt_thresh  = thresh_ff;
    nxt_ien     = ien_ff;
    clr         = '0;
    if (aw_have_ff && w_have_ff && !bvalid_ff) begin
      nxt_aw_have = 1'b0;
      nxt_w_have  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = dpc_pkg::RESP_OK;
      case (awaddr_ff)
        dpc_pkg::ADDR_CTRL: nxt_thresh = strb_merge(thresh_ff, wdata_ff, wstrb_ff);
        dpc_pkg::ADDR_IRQ_CLR: clr = wstrb_ff[0] ? wdata_ff[QW-1:0] : '0;
        dpc_pkg::ADDR_IRQ_EN: begin
          if (wstrb_ff[0]) begin
            nxt_ien = wdata_ff[QW-1:0];
          end
        end
        dpc_pkg::ADDR_STATE, dpc_pkg::ADDR_IRQ_ST: nxt_bresp = dpc_pkg::RESP_OK;
        default: nxt_bresp = dpc_pkg::RESP_ERR;
      endcase
    end
    state_word = '0;
    state_word[dpc_pkg::ST_SLOW]   = (pwr_ff == dpc_pkg::PWR_SLOW);
    state_word[dpc_pkg::ST_CORE_A] = core_on[0];
    state_word[dpc_pkg::ST_CORE_B] = core_on[1];
    state_word[dpc_pkg::ST_PDS]    = pds;
    state_word[dpc_pkg::ST_OE_A]   = oe[0];
    state_word[dpc_pkg::ST_OE_B]   = oe[1];
    nxt_rvalid = rvalid_ff & ~s_axi_rready;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = dpc_pkg::RESP_OK;
      case (s_axi_araddr)
        dpc_pkg::ADDR_CTRL:    nxt_rdata = 32'(thresh_ff);
        dpc_pkg::ADDR_STATE:   nxt_rdata = state_word;
        dpc_pkg::ADDR_IRQ_ST:  nxt_rdata = 32'(ist_ff);
        dpc_pkg::ADDR_IRQ_CLR: nxt_rdata = '0;
        dpc_pkg::ADDR_IRQ_EN:  nxt_rdata = 32'(ien_ff);
        default: begin
          nxt_rdata = '0;
          nxt_rresp = dpc_pkg::RESP_ERR;
        end
      endcase
    end
    // A new event outranks a clear landing in the same cycle.
    ev = '0;
    ev[dpc_pkg::IRQ_OVR_A] = nxt_ovr[0] & ~ovr_ff[0];
    ev[dpc_pkg::IRQ_OVR_B] = nxt_ovr[1] & ~ovr_ff[1];
    ev[dpc_pkg::IRQ_SLOW]  = ev_slow;
    ev[dpc_pkg::IRQ_WAKE]  = ev_wake;
    nxt_ist = (ist_ff & ~clr) | ev;
    nxt_irq = |(nxt_ist & nxt_ien);
    dummy_unused = '0;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_have_ff    <= 1'b0;
      w_have_ff     <= 1'b0;
      bvalid_ff     <= 1'b0;
      rvalid_ff     <= 1'b0;
      awaddr_ff     <= '0;
      wdata_ff      <= '0;
      wstrb_ff      <= '0;
      bresp_ff      <= '0;
      rresp_ff      <= '0;
      rdata_ff      <= '0;
      thresh_ff     <= dpc_pkg::CTRL_RST;
      ist_ff        <= '0;
      ien_ff        <= '0;
      irq_ff        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      aw_have_ff    <= nxt_aw_have;
      w_have_ff     <= nxt_w_have;
      bvalid_ff     <= nxt_bvalid;
      rvalid_ff     <= nxt_rvalid;
      awaddr_ff     <= nxt_awaddr;
      wdata_ff      <= nxt_wdata;
      wstrb_ff      <= nxt_wstrb;
      bresp_ff      <= nxt_bresp;
      rresp_ff      <= nxt_rresp;
      rdata_ff      <= nxt_rdata;
      thresh_ff     <= nxt_thresh;
      ist_ff        <= nxt_ist;
      ien_ff        <= nxt_ien;
      irq_ff        <= nxt_irq;
      s_axi_awready <= ~nxt_aw_have & ~nxt_bvalid;
      s_axi_wready  <= ~nxt_w_have & ~nxt_bvalid;
      s_axi_arready <= ~nxt_rvalid;
    end
  end

  always_comb begin
    s_axi_bvalid = bvalid_ff;
    s_axi_bresp  = bresp_ff;
    s_axi_rvalid = rvalid_ff;
    s_axi_rdata  = rdata_ff;
    s_axi_rresp  = rresp_ff;
    irq          = irq_ff;
  end
endmodule : dpc_top
`default_nettype wire

// *** dv/dpc_monitor.sv ***
// Purpose: Concurrent checks on the converter output and power pins.
// Assumes: Enable and power pins are held for many clocks by the bench.
// Notes:   Bound to dpc_top from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module dpc_monitor (
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire logic                      sample_clk,
  input  wire logic                      power_down_select,
  input  wire logic                      chan_a_output_enable,
  input  wire logic                      chan_b_output_enable,
  input  wire logic [dpc_pkg::SMP_W-1:0] chan_a_sample,
  input  wire logic [dpc_pkg::SMP_W-1:0] chan_b_sample,
  input  wire logic                      chan_a_overrange_flag,
  input  wire logic                      chan_b_overrange_flag,
  input  wire logic                      chan_a_data_ready_clock,
  input  wire logic                      chan_b_data_ready_clock,
  input  wire logic                      chan_a_out_oe,
  input  wire logic                      chan_b_out_oe
);
  // ==========================================================
  // Stall counter
  // It saturates, so a long stop never wraps back into a false run.
  logic [7:0] stall_ff;
  logic [7:0] nxt_stall;
  logic       sclk_ff;
  logic       nxt_sclk;
  always_comb begin
    nxt_sclk  = sample_clk;
    nxt_stall = (sample_clk != sclk_ff) ? 8'h00 : stall_ff + {7'h00, stall_ff != 8'hff};
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stall_ff <= 8'h00;
      sclk_ff  <= 1'b0;
    end else begin
      stall_ff <= nxt_stall;
      sclk_ff  <= nxt_sclk;
    end
  end
  // ==========================================================
  // Assertions
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_oe_a_on: assert property ($rose(chan_a_output_enable) |-> ##[1:4] chan_a_out_oe)
    else $error("channel A drive did not follow its enable");
  a_oe_a_off: assert property ($fell(chan_a_output_enable) |-> ##[1:4] !chan_a_out_oe)
    else $error("channel A release did not follow its enable");
  a_oe_b_on: assert property ($rose(chan_b_output_enable) |-> ##[1:4] chan_b_out_oe)
    else $error("channel B drive did not follow its enable");
  a_oe_b_off: assert property ($fell(chan_b_output_enable) |-> ##[1:4] !chan_b_out_oe)
    else $error("channel B release did not follow its enable");
  a_ovr_a_limit: assert property (chan_a_overrange_flag == (chan_a_sample inside {14'h1fff, 14'h2000}))
    else $error("channel A overrange flag disagrees with word");
  a_ovr_b_limit: assert property (chan_b_overrange_flag == (chan_b_sample inside {14'h1fff, 14'h2000}))
    else $error("channel B overrange flag disagrees with word");
  a_core_a_off: assert property ((power_down_select && !chan_a_output_enable)[*8] |->
    chan_a_sample == 14'h0000 && !chan_a_data_ready_clock)
    else $error("channel A core still running in power-down");
  a_core_b_off: assert property ((power_down_select && !chan_b_output_enable)[*8] |->
    chan_b_sample == 14'h0000 && !chan_b_data_ready_clock)
    else $error("channel B core still running in power-down");
  a_ready_low_high: assert property (sample_clk[*4] |-> ##1 !chan_a_data_ready_clock)
    else $error("data-ready high while sample clock high");
  a_slow_power_off: assert property (stall_ff >= 8'd60 |->
    chan_a_sample == 14'h0000 && chan_b_sample == 14'h0000 && !chan_b_data_ready_clock)
    else $error("cores still running with sample clock stopped");
endmodule : dpc_monitor
`default_nettype wire

// *** dv/dpc_capture_model.sv ***
// Purpose: Capture logic on the far side of one converter channel.
// Assumes: Released pins have no pull, so they show the inverse of their last level.
// Notes:   Captures on each rising edge of the data-ready clock it sees.
`timescale 1ns/1ps
`default_nettype none
module dpc_capture_model (
  input  wire logic [dpc_pkg::SMP_W-1:0] word,
  input  wire logic                      overrange_flag,
  input  wire logic                      drc,
  input  wire logic                      oe,
  output var  logic [dpc_pkg::SMP_W-1:0] cap_word,
  output var  logic                      cap_ovr
);
  // ==========================================================
  // Pin view
  logic [dpc_pkg::SMP_W+1:0] held;
  logic                      drc_seen;
  initial held = '0;
  always @* if (oe) held = {drc, overrange_flag, word};
  assign drc_seen = oe ? drc : ~held[dpc_pkg::SMP_W+1];
  // ==========================================================
  // Capture
  always @(posedge drc_seen) begin
    cap_word <= oe ? word : ~held[dpc_pkg::SMP_W-1:0];
    cap_ovr  <= oe ? overrange_flag : ~held[dpc_pkg::SMP_W];
  end
endmodule : dpc_capture_model
`default_nettype wire

// *** dv/dpc_tb_top.sv ***
// Purpose: Self-checking bench for the dual converter output and power control.
// Assumes: Latency is shortened to keep the run short.
// Notes:   Registers reached over AXI4-Lite; sample clock stops only when asked.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module dpc_tb_top;
  localparam int LAT = 5;
  logic        clock = 0, rst = 1, sample_clk = 0, sclk_run = 1;
  logic        power_down_select = 0, chan_a_output_enable = 1, chan_b_output_enable = 1;
  logic [15:0] chan_a_analog = '0, chan_b_analog = '0;
  logic [13:0] chan_a_sample, chan_b_sample, cap_word;
  logic        chan_a_overrange_flag, chan_b_overrange_flag, cap_ovr, irq;
  logic        chan_a_data_ready_clock, chan_b_data_ready_clock, chan_a_out_oe, chan_b_out_oe;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  int          fail_count = 0, check_count = 0;
  // ==========================================================
  // Clocks
  always #10 clock = ~clock;
  // The sample clock keeps an even duty and an offset phase from the system clock.
  initial begin
    #3;
    forever begin
      #80;
      if (sclk_run) sample_clk = ~sample_clk;
    end
  end
  // ==========================================================
  // Design and far side
  dpc_top #(.LAT_X2(LAT)) dut_u (.*, .s_axi_wstrb(4'hf));
  dpc_capture_model cap_u (.word(chan_a_sample), .overrange_flag(chan_a_overrange_flag),
    .drc(chan_a_data_ready_clock), .oe(chan_a_out_oe), .cap_word(cap_word), .cap_ovr(cap_ovr));
  // ==========================================================
  // Bus tasks
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic timeout(input int n);
    if (n >= 200) begin
      fail_count++;
      $display("ERROR bus wait expected 1 seen 0");
      end_sim();
    end
  endtask : timeout
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic tb;
    n = 0;
    tb = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb && n < 200) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      n++;
    end
    s_axi_bready <= 1'b0;
    timeout(n);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic tr;
    n = 0;
    tr = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr && n < 200) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      n++;
    end
    s_axi_rready <= 1'b0;
    timeout(n);
  endtask : axi_rd
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : settle
  // ==========================================================
  // Tests
  logic [15:0] ins [6] = '{16'h7fff, 16'h8000, 16'h1fff, 16'he000, 16'h0123, 16'hfedc};
  logic [13:0] wds [6] = '{14'h1fff, 14'h2000, 14'h1fff, 14'h2000, 14'h0123, 14'h3edc};
  initial begin
    repeat (100000) @(posedge clock);
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    for (int m = 0; m < 8; m++) begin
      @(posedge clock);
      {power_down_select, chan_a_output_enable, chan_b_output_enable} <= m[2:0];
      settle(14);
      axi_rd(dpc_pkg::ADDR_STATE, rd, rsp);
      `CHK("state", {26'h0, m[0], m[1], m[2], !m[2] || m[0], !m[2] || m[1], 1'b0}, rd)
      `CHK("oe a", m[1], chan_a_out_oe)
      `CHK("oe b", m[0], chan_b_out_oe)
    end
    $display("test power table done");
    {power_down_select, chan_a_output_enable, chan_b_output_enable} <= 3'b011;
    for (int i = 0; i < 6; i++) begin
      chan_a_analog <= ins[i];
      chan_b_analog <= ins[(i + 1) % 6];
      settle(60);
      `CHK("word a", wds[i], chan_a_sample)
      `CHK("word b", wds[(i + 1) % 6], chan_b_sample)
      `CHK("flag a", i < 4, chan_a_overrange_flag)
      `CHK("captured a", wds[i], cap_word)
      `CHK("captured flag", i < 4, cap_ovr)
    end
    $display("test format done");
    chan_a_analog <= 16'h0011;
    settle(60);
    @(posedge sample_clk);
    @(posedge clock);
    chan_a_analog <= 16'h0022;
    repeat ((LAT + 1) / 2) @(posedge sample_clk);
    `CHK("word early", 14'h0011, chan_a_sample)
    settle(6);
    `CHK("word late", 14'h0022, chan_a_sample)
    $display("test latency done");
    axi_rd(dpc_pkg::ADDR_CTRL, rd, rsp);
    `CHK("ctrl reset", 32'(dpc_pkg::CTRL_RST), rd)
    axi_wr(dpc_pkg::ADDR_CTRL, 32'h0000000a, rsp);
    axi_wr(dpc_pkg::ADDR_IRQ_CLR, 32'h0000000f, rsp);
    axi_wr(dpc_pkg::ADDR_IRQ_EN, 32'h00000004, rsp);
    @(negedge sample_clk);
    sclk_run = 0;
    settle(70);
    axi_rd(dpc_pkg::ADDR_STATE, rd, rsp);
    `CHK("slow", 1'b1, rd[dpc_pkg::ST_SLOW])
    `CHK("word idle", 14'h0000, chan_a_sample)
    `CHK("irq on", 1'b1, irq)
    axi_wr(dpc_pkg::ADDR_IRQ_EN, 32'h00000000, rsp);
    settle(2);
    `CHK("irq masked", 1'b0, irq)
    axi_wr(dpc_pkg::ADDR_IRQ_CLR, 32'h00000004, rsp);
    axi_rd(dpc_pkg::ADDR_IRQ_ST, rd, rsp);
    `CHK("status clear", 32'h0, rd)
    sclk_run = 1;
    settle(60);
    axi_rd(dpc_pkg::ADDR_IRQ_ST, rd, rsp);
    `CHK("wake", 32'ha, rd)
    axi_rd(dpc_pkg::ADDR_STATE, rd, rsp);
    `CHK("running", 1'b0, rd[dpc_pkg::ST_SLOW])
    $display("test slow clock done");
    axi_wr(8'h40, 32'h1, rsp);
    `CHK("bad write", dpc_pkg::RESP_ERR, rsp)
    axi_rd(8'h40, rd, rsp);
    `CHK("bad read", dpc_pkg::RESP_ERR, rsp)
    `CHK("bad data", 32'h0, rd)
    $display("test bus errors done");
    end_sim();
  end
endmodule : dpc_tb_top
bind dpc_top dpc_monitor mon_u (.clock(clock), .rst(rst), .sample_clk(sample_clk),
  .power_down_select(power_down_select), .chan_a_output_enable(chan_a_output_enable),
  .chan_b_output_enable(chan_b_output_enable), .chan_a_sample(chan_a_sample),
  .chan_b_sample(chan_b_sample), .chan_a_overrange_flag(chan_a_overrange_flag),
  .chan_b_overrange_flag(chan_b_overrange_flag), .chan_a_out_oe(chan_a_out_oe),
  .chan_a_data_ready_clock(chan_a_data_ready_clock), .chan_b_out_oe(chan_b_out_oe),
  .chan_b_data_ready_clock(chan_b_data_ready_clock));
`default_nettype wire
